// file: logic/ccd_alu.sv
// alu: result and zero flag for the file-register operations
`timescale 1ns/1ns
`default_nettype none
module ccd_alu
    import ccd_pkg::*;
(
    input wire ccd_op_t op,
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output logic zero
);
    always_comb begin
        unique case (op)
            CCD_OP_INVERT_FILE: result = ~operand;
            CCD_OP_MINUS_ONE_FILE: result = operand - 8'h01;
            default: result = ZERO_BYTE;
        endcase
        zero = (result == ZERO_BYTE);
    end
endmodule
`default_nettype wire

// file: logic/ccd_exec.sv
// executor for call, clear, complement and decrement instructions
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - immediate call pushes pc plus one first
// - immediate call loads k and page_latch 6..3
// - both calls two cycles, flags untouched
// - indirect call pushes, loads w and page_latch
// - watchdog clear zeroes counter, prescaler, sets bits
// - invert file to destination, zero flag only
// - decrement file, d selects w or file
// - zero file writes zero, sets zero flag
// - zero work clears w, sets zero flag
module ccd_exec
    import ccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire ccd_op_t op_code,
    input wire logic [IMM_W-1:0] op_imm,
    input wire logic [FADDR_W-1:0] op_faddr,
    input wire logic op_dest,
    input wire logic [7:0] page_latch,
    input wire logic [7:0] file_rdata,
    input wire logic watchdog_tick,
    output logic busy,
    output logic [PC_W-1:0] pc,
    output logic stack_push,
    output logic [PC_W-1:0] stack_top,
    output logic file_we,
    output logic [FADDR_W-1:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic [7:0] wreg,
    output logic zero_flag,
    output logic timeout_status_bit,
    output logic powerdown_status_bit,
    output logic [7:0] watchdog_counter,
    output logic [7:0] watchdog_prescaler
);
    ccd_state_t state;
    logic [PC_W-1:0] call_target;
    logic [7:0] alu_result;
    logic alu_zero;
    logic take;
    logic take_call;
    logic take_alu;
    logic take_clear;
    logic wdog_wrap;

    // both call forms share the push and the dead second cycle
    function automatic logic is_call(input ccd_op_t code);
        return (code == CCD_OP_CALL) || (code == CCD_OP_CALL_INDIRECT);
    endfunction

    // only invert and decrement route their result through the alu
    function automatic logic uses_alu(input ccd_op_t code);
        return (code == CCD_OP_INVERT_FILE) ||
               (code == CCD_OP_MINUS_ONE_FILE);
    endfunction

    // a new op is only taken while idle; busy stalls the fetch side
    assign take = op_valid && (state == CCD_ST_IDLE);
    assign take_call = take && is_call(op_code);
    assign take_alu = take && uses_alu(op_code);
    assign take_clear = take && (op_code == CCD_OP_WATCHDOG_CLEAR);
    assign busy = (state == CCD_ST_CALL2);
    // the counter steps once per full turn of the prescaler
    assign wdog_wrap = watchdog_tick && (watchdog_prescaler == 8'hff);

    // the operand is the file content read in the same cycle as the op
    ccd_alu u_alu (
        .op(op_code),
        .operand(file_rdata),
        .result(alu_result),
        .zero(alu_zero)
    );

    // second cycle of a call is a dead slot, as the fetched word is discarded
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= CCD_ST_IDLE;
        end else begin
            unique case (state)
                CCD_ST_IDLE: begin
                    if (take_call) begin
                        state <= CCD_ST_CALL2;
                    end
                end
                CCD_ST_CALL2: state <= CCD_ST_IDLE;
            endcase
        end
    end

    // the target is latched at the take, so page_latch and wreg may move on
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            call_target <= PC_RESET;
        end else if (take && op_code == CCD_OP_CALL) begin
            call_target <= {page_latch[6:3], op_imm};
        end else if (take && op_code == CCD_OP_CALL_INDIRECT) begin
            call_target <= {page_latch[6:0], wreg};
        end
    end

    // pc steps past every taken op; a call overwrites it one cycle later
    // so the push always sees the address just after the call being taken
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc <= PC_RESET;
        end else if (take) begin
            pc <= pc + 15'h0001;
        end else if (busy) begin
            pc <= call_target;
        end
    end

    // push strobes in the second call cycle, while pc holds the return address, before pc takes the target
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stack_push <= 1'b0;
        end else begin
            stack_push <= take_call;
        end
    end

    // the stack itself sits outside; only the return address is offered
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stack_top <= PC_RESET;
        end else if (take_call) begin
            stack_top <= pc + 15'h0001;
        end
    end

    // file port: a one-cycle strobe with address and data behind it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            file_we <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= ZERO_BYTE;
        end else begin
            file_we <= 1'b0;
            if (take_alu && op_dest) begin
                file_we <= 1'b1;
                file_waddr <= op_faddr;
                file_wdata <= alu_result;
            end else if (take && op_code == CCD_OP_ZERO_FILE) begin
                file_we <= 1'b1;
                file_waddr <= op_faddr;
                file_wdata <= ZERO_BYTE;
            end
        end
    end

    // wreg is the only destination besides the file port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wreg <= WREG_RESET;
        end else if (take_alu && !op_dest) begin
            wreg <= alu_result;
        end else if (take && op_code == CCD_OP_ZERO_WORK) begin
            wreg <= ZERO_BYTE;
        end
    end

    // calls and watchdog clear leave the flag alone
    // the clears force it high whatever the old value was
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            zero_flag <= 1'b0;
        end else if (take_alu) begin
            zero_flag <= alu_zero;
        end else if (take && (op_code == CCD_OP_ZERO_FILE ||
                              op_code == CCD_OP_ZERO_WORK)) begin
            zero_flag <= 1'b1;
        end
    end

    // watchdog clear wins over a same-cycle tick so the clear is never lost
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            watchdog_prescaler <= PRESC_RESET;
        end else if (take_clear) begin
            watchdog_prescaler <= PRESC_RESET;
        end else if (watchdog_tick) begin
            watchdog_prescaler <= watchdog_prescaler + 8'h01;
        end
    end

    // clear and tick share the priority order of the prescaler
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            watchdog_counter <= WDOG_RESET;
        end else if (take_clear) begin
            watchdog_counter <= WDOG_RESET;
        end else if (wdog_wrap) begin
            watchdog_counter <= watchdog_counter + 8'h01;
        end
    end

    // a counter wrap is a time-out; only reset or a clear sets the bit again
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            timeout_status_bit <= 1'b1;
        end else if (take_clear) begin
            timeout_status_bit <= 1'b1;
        end else if (wdog_wrap && watchdog_counter == 8'hff) begin
            timeout_status_bit <= 1'b0;
        end
    end

    // this subset has no sleep op, so the power-down bit never drops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            powerdown_status_bit <= 1'b1;
        end else if (take_clear) begin
            powerdown_status_bit <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: pkg/ccd_pkg.sv
// package: constants and types for the call/clear/decrement executor
`default_nettype none
package ccd_pkg;
    localparam int PC_W = 15;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int IMM_W = 11;
    localparam int CALL_CYCLES = 2;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam logic [7:0] PRESC_RESET = 8'h00;

    typedef enum logic [2:0] {
        CCD_OP_NONE = 3'h0,
        CCD_OP_CALL = 3'h1,
        CCD_OP_CALL_INDIRECT = 3'h2,
        CCD_OP_WATCHDOG_CLEAR = 3'h3,
        CCD_OP_INVERT_FILE = 3'h4,
        CCD_OP_ZERO_FILE = 3'h5,
        CCD_OP_ZERO_WORK = 3'h6,
        CCD_OP_MINUS_ONE_FILE = 3'h7
    } ccd_op_t;

    typedef enum logic [0:0] {
        CCD_ST_IDLE = 1'b0,
        CCD_ST_CALL2 = 1'b1
    } ccd_state_t;
endpackage
`default_nettype wire

// file: verif/ccd_exec_monitor.sv
// checker: port-level properties of the executor
`timescale 1ns/1ns
`default_nettype none
module ccd_exec_monitor
    import ccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic op_dest,
    input wire logic busy,
    input wire logic stack_push,
    input wire ccd_op_t op_code,
    input wire logic [IMM_W-1:0] op_imm,
    input wire logic [FADDR_W-1:0] op_faddr,
    input wire logic [7:0] page_latch,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] wreg,
    input wire logic [7:0] watchdog_counter,
    input wire logic [7:0] watchdog_prescaler,
    input wire logic [PC_W-1:0] pc,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic file_we,
    input wire logic [FADDR_W-1:0] file_waddr,
    input wire logic zero_flag,
    input wire logic timeout_status_bit,
    input wire logic powerdown_status_bit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic dst_q;
    always_ff @(posedge clk_sys) dst_q <= op_dest;
    wire take = op_valid && !busy;
    wire calls = take && op_code inside {CCD_OP_CALL, CCD_OP_CALL_INDIRECT};
    wire [3:0] pl_hi = page_latch[6:3];
    wire [6:0] pl_lo = page_latch[6:0];
    // destination as seen one cycle after the take
    wire [7:0] res = dst_q ? file_wdata : wreg;
    property p_push; calls |=> stack_push && busy &&
        stack_top == $past(pc) + 15'h0001; endproperty
    a_push: assert property (p_push) else $error("bad push");
    property p_imm; take && op_code == CCD_OP_CALL |=>
        ##1 pc == {$past(pl_hi, 2), $past(op_imm, 2)}; endproperty
    a_imm: assert property (p_imm) else $error("bad call target");
    property p_ind; take && op_code == CCD_OP_CALL_INDIRECT |=>
        ##1 pc == {$past(pl_lo, 2), $past(wreg, 2)}; endproperty
    a_ind: assert property (p_ind) else $error("bad indirect");
    property p_two; calls |=> busy && $stable(zero_flag)
        ##1 !busy && $stable(zero_flag); endproperty
    a_two: assert property (p_two) else $error("bad call length");
    property p_wdt; take && op_code == CCD_OP_WATCHDOG_CLEAR |=>
        watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00 &&
        timeout_status_bit && powerdown_status_bit; endproperty
    a_wdt: assert property (p_wdt) else $error("bad wdog clear");
    property p_inv; take && op_code == CCD_OP_INVERT_FILE |=>
        file_we == dst_q && res == ~$past(file_rdata); endproperty
    a_inv: assert property (p_inv) else $error("bad invert");
    property p_dec; take && op_code == CCD_OP_MINUS_ONE_FILE |=>
        file_we == dst_q && res == $past(file_rdata) - 8'h01; endproperty
    a_dec: assert property (p_dec) else $error("bad decrement");
    property p_zf; take && op_code inside {CCD_OP_INVERT_FILE,
        CCD_OP_MINUS_ONE_FILE} |=> zero_flag == (res == 8'h00); endproperty
    a_zf: assert property (p_zf) else $error("bad zero flag");
    property p_op_zero_file; take && op_code == CCD_OP_ZERO_FILE |=>
        file_we && file_wdata == 8'h00 && zero_flag &&
        file_waddr == $past(op_faddr); endproperty
    a_op_zero_file: assert property (p_op_zero_file) else $error("bad file clear");
    property p_op_zero_work; take && op_code == CCD_OP_ZERO_WORK |=>
        wreg == 8'h00 && zero_flag; endproperty
    a_op_zero_work: assert property (p_op_zero_work) else $error("bad work clear");
    cover property (calls ##1 op_valid && busy);
    cover property (take && op_code == CCD_OP_CALL_INDIRECT);
    cover property (take && op_code == CCD_OP_WATCHDOG_CLEAR);
endmodule
bind ccd_exec ccd_exec_monitor u_mon (.*);
`default_nettype wire

// file: verif/test_call_clear_decrement_ops.sv
// testbench: directed and random operations checked through a queue
`timescale 1ns/1ns
`default_nettype none
module test_call_clear_decrement_ops
    import ccd_pkg::*;
;
    logic clk_sys = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_dest = 1'b0;
    logic watchdog_tick = 1'b0;
    ccd_op_t op_code = CCD_OP_NONE;
    logic [IMM_W-1:0] op_imm = 11'h000;
    logic [FADDR_W-1:0] op_faddr = 7'h00, file_waddr;
    logic [7:0] page_latch = 8'h00, file_rdata = 8'h00, exp_w = 8'h00;
    logic busy, stack_push, file_we, zero_flag;
    logic timeout_status_bit, powerdown_status_bit;
    logic [PC_W-1:0] pc, stack_top, exp_pc = 15'h0000;
    logic [7:0] file_wdata, wreg, watchdog_counter, watchdog_prescaler;
    logic [15:0] notes[$];
    logic [15:0] seen;
    integer seed = 32'h5c1d;
    int n_errors = 0;
    int tests_run = 0;
    ccd_exec dut (.*);
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) watchdog_tick <= 1'($random(seed));
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // the call stays offered while busy, so its refusal is exercised too
    task automatic run(ccd_op_t c, logic d, logic [7:0] r);
        logic [7:0] v, pl;
        logic [10:0] k;
        logic [6:0] f;
        k = 11'($random(seed));
        pl = 8'($random(seed));
        f = 7'($random(seed));
        v = c == CCD_OP_INVERT_FILE ? ~r :
            c == CCD_OP_MINUS_ONE_FILE ? r - 8'h01 : 8'h00;
        {op_valid, op_dest, file_rdata} <= {1'b1, d, r};
        op_code <= c;
        {op_imm, page_latch, op_faddr} <= {k, pl, f};
        exp_pc = exp_pc + 15'h0001;
        if (c == CCD_OP_CALL || c == CCD_OP_CALL_INDIRECT) begin
            notes.push_back({1'b0, exp_pc});
            exp_pc = c == CCD_OP_CALL ? {pl[6:3], k} : {pl[6:0], exp_w};
        end else if (c == CCD_OP_ZERO_FILE || (d && c[2] && c[1:0] != 2'h2))
            notes.push_back({v == 8'h00, f, v});
        else if (c[2])
            exp_w = v;
        @(posedge clk_sys);
        if (c == CCD_OP_CALL || c == CCD_OP_CALL_INDIRECT)
            @(posedge clk_sys);
    endtask
    always @(negedge clk_sys) begin
        if (!sys_rst && (file_we === 1'b1 || stack_push === 1'b1)) begin
            if (stack_push)
                seen = {1'b0, stack_top};
            else
                seen = {zero_flag, file_waddr, file_wdata};
            tests_run++;
            if (notes.size() == 0 || notes[0] !== seen) begin
                n_errors++;
                $display("unexpected result: expected %h seen %h",
                         notes[0], seen);
            end
            if (notes.size() != 0)
                void'(notes.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 1; i < 16; i++)
            run(ccd_op_t'(i[2:0]), i[3], i[3] ? 8'h01 : 8'hff);
        repeat (60)
            run(ccd_op_t'(3'($random(seed))), 1'($random(seed)),
                8'($random(seed)));
        op_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        tests_run++;
        if (notes.size() != 0) begin
            n_errors++;
            $display("unexpected notes left: expected 0 seen %0d",
                     notes.size());
        end
        close_out();
    end
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
